// File: verilog/dcas_pkg.sv
// Constants and helpers for the daisy-chain address selector
package dcas_pkg;
  // ****************************************
  // Character codes
  // ****************************************
  localparam logic [7:0] CH_WILD = 8'h2a;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_GLOBAL = 8'h5c;
  localparam logic [7:0] CH_PROMPT = 8'h3e;
  localparam logic [7:0] CH_EQUALS = 8'h3d;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_K = 8'h4b;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_Z = 8'h5a;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ****************************************
  // Reset values and message sizes
  // ****************************************
  localparam logic [7:0] ID_FACTORY = CH_WILD;
  localparam int MSG_DEPTH = 4;
  localparam logic [2:0] LEN_READBACK = 3'h4;
  localparam logic [2:0] LEN_PROMPT_ID = 3'h2;
  localparam logic [2:0] LEN_PROMPT = 3'h1;

  // ****************************************
  // Line parser states
  // ****************************************
  typedef enum logic [2:0] {
    PS_START = 3'b000,
    PS_AT = 3'b001,
    PS_SELECT_RESPONDER_COMMAND = 3'b010,
    PS_SELECT_RESPONDER_COMMAND_ID = 3'b011,
    PS_BODY = 3'b100
  } dcas_pstate_t;

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    return (c >= CH_LOW_A && c <= CH_LOW_Z) ? (c & ~CASE_BIT) : c;
  endfunction

  // Digit or letter, either case
  function automatic logic is_id_char(input logic [7:0] c);
    logic [7:0] u;
    u = to_upper(c);
    return (u >= CH_0 && u <= CH_9) || (u >= CH_A && u <= CH_Z);
  endfunction

  function automatic logic [7:0] select_responder_command_char(input logic [1:0] idx);
    case (idx)
      2'h0: return CH_T;
      2'h1: return CH_A;
      2'h2: return CH_L;
      default: return CH_K;
    endcase
  endfunction
endpackage

// File: verilog/dcas_top.sv
// Daisy-chain address selector: identifier, selection and prompt output
// ****************************************
// ****************************************
module dcas_top
  import dcas_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_ID_WR,
  input wire logic [7:0] I_ID_WR_DATA,
  input wire logic I_ID_RD,
  input wire logic I_PROMPT_REQ,
  input wire logic I_SAVE,
  input wire logic [7:0] I_NV_ID,
  input wire logic I_NV_VALID,
  input wire logic I_TX_READY,
  output logic O_CMD_EN,
  output logic O_TX_EN,
  output logic O_SELECTED,
  output logic O_READY,
  output logic [7:0] O_ID,
  output logic O_TX_VALID,
  output logic [7:0] O_TX_DATA,
  output logic O_NV_WR,
  output logic [7:0] O_NV_DATA
);

  // ****************************************
  // Identifier store
  // ****************************************
  logic [7:0] id_reg;
  logic [7:0] id_next;
  logic restored_reg;
  logic restored_next;
  logic nv_wr_reg;
  logic nv_wr_next;
  logic [7:0] nv_data_reg;
  logic [7:0] nv_data_next;
  logic id_wr_ok;
  logic is_wild;

  assign is_wild = (id_reg == CH_WILD);
  // Ignored before restore, so a write cannot be overrun by the load
  assign id_wr_ok = restored_reg && I_ID_WR &&
                    (is_id_char(I_ID_WR_DATA) || I_ID_WR_DATA == CH_WILD);

  always_comb begin
    id_next = id_reg;
    restored_next = 1'b1;
    nv_wr_next = 1'b0;
    nv_data_next = nv_data_reg;
    if (!restored_reg) begin
      // Store sampled one cycle after reset, never inside it
      if (I_NV_VALID && is_id_char(I_NV_ID)) begin
        id_next = to_upper(I_NV_ID);
      end else begin
        id_next = ID_FACTORY;
      end
    end else if (id_wr_ok) begin
      id_next = to_upper(I_ID_WR_DATA);
    end
    if (restored_reg && I_SAVE) begin
      nv_wr_next = 1'b1;
      nv_data_next = id_reg;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      id_reg <= ID_FACTORY;
      restored_reg <= 1'b0;
      nv_wr_reg <= 1'b0;
      nv_data_reg <= ID_FACTORY;
    end else begin
      id_reg <= id_next;
      restored_reg <= restored_next;
      nv_wr_reg <= nv_wr_next;
      nv_data_reg <= nv_data_next;
    end
  end

  // ****************************************
  // Line parser and selection
  // ****************************************
  dcas_pstate_t ps_reg;
  dcas_pstate_t ps_next;
  logic [1:0] select_responder_command_idx_reg;
  logic [1:0] select_responder_command_idx_next;
  logic selected_reg;
  logic selected_next;
  logic global_reg;
  logic global_next;
  logic [7:0] rx_up;
  logic rx_eol;
  logic tx_en;

  assign rx_up = to_upper(I_RX_DATA);
  assign rx_eol = (I_RX_DATA == CH_CR) || (I_RX_DATA == CH_LF);

  always_comb begin
    ps_next = ps_reg;
    select_responder_command_idx_next = select_responder_command_idx_reg;
    selected_next = selected_reg;
    global_next = global_reg;
    if (I_RX_VALID) begin
      if (rx_eol) begin
        // Global flag outlives the line so its answer and prompt get out
        ps_next = PS_START;
      end else begin
        unique case (ps_reg)
          PS_START: begin
            global_next = (I_RX_DATA == CH_GLOBAL);
            select_responder_command_idx_next = 2'h1;
            if (I_RX_DATA == CH_AT) begin
              ps_next = PS_AT;
            end else if (rx_up == CH_T) begin
              ps_next = PS_SELECT_RESPONDER_COMMAND;
            end else begin
              ps_next = PS_BODY;
            end
          end
          PS_SELECT_RESPONDER_COMMAND: begin
            if (rx_up != select_responder_command_char(select_responder_command_idx_reg)) begin
              ps_next = PS_BODY;
            end else if (select_responder_command_idx_reg == 2'h3) begin
              ps_next = PS_SELECT_RESPONDER_COMMAND_ID;
            end else begin
              select_responder_command_idx_next = select_responder_command_idx_reg + 2'h1;
            end
          end
          PS_AT, PS_SELECT_RESPONDER_COMMAND_ID: begin
            ps_next = PS_BODY;
            // Wildcard devices answer anyway; selection only matters later
            if (is_id_char(I_RX_DATA) && !is_wild) begin
              selected_next = (rx_up == id_reg);
            end
          end
          PS_BODY: begin
            ps_next = PS_BODY;
          end
        endcase
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ps_reg <= PS_START;
      select_responder_command_idx_reg <= 2'h0;
      selected_reg <= 1'b0;
      global_reg <= 1'b0;
    end else begin
      ps_reg <= ps_next;
      select_responder_command_idx_reg <= select_responder_command_idx_next;
      selected_reg <= selected_next;
      global_reg <= global_next;
    end
  end

  // Selection survives an identifier change: it is not tied to the value
  assign tx_en = restored_reg && (is_wild || selected_reg || global_reg);

  // ****************************************
  // Prompt and readback transmitter
  // ****************************************
  logic [7:0] msg_reg [MSG_DEPTH];
  logic [7:0] msg_next [MSG_DEPTH];
  logic [2:0] left_reg;
  logic [2:0] left_next;
  logic prompt_pend_reg;
  logic prompt_pend_next;
  logic read_pend_reg;
  logic read_pend_next;
  logic busy;
  logic tx_take;

  assign busy = (left_reg != 3'h0);
  assign tx_take = busy && I_TX_READY;

  always_comb begin
    msg_next = msg_reg;
    left_next = left_reg;
    prompt_pend_next = prompt_pend_reg;
    read_pend_next = read_pend_reg;
    if (tx_take) begin
      for (int i = 0; i < MSG_DEPTH - 1; i++) begin
        msg_next[i] = msg_reg[i + 1];
      end
      left_next = left_reg - 3'h1;
    end else if (!busy) begin
      if (!tx_en) begin
        // Silent device drops what it may not say
        prompt_pend_next = 1'b0;
        read_pend_next = 1'b0;
      end else if (read_pend_reg) begin
        msg_next[0] = CH_I;
        msg_next[1] = CH_D;
        msg_next[2] = CH_EQUALS;
        msg_next[3] = id_reg;
        left_next = LEN_READBACK;
        read_pend_next = 1'b0;
      end else if (prompt_pend_reg) begin
        if (is_wild) begin
          msg_next[0] = CH_PROMPT;
          left_next = LEN_PROMPT;
        end else begin
          msg_next[0] = id_reg;
          msg_next[1] = CH_PROMPT;
          left_next = LEN_PROMPT_ID;
        end
        prompt_pend_next = 1'b0;
      end
    end
    // A request in the cycle its flag is consumed is kept
    if (I_ID_RD) begin
      read_pend_next = 1'b1;
    end
    if (I_PROMPT_REQ || (id_wr_ok && tx_en)) begin
      prompt_pend_next = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      for (int i = 0; i < MSG_DEPTH; i++) begin
        msg_reg[i] <= 8'h00;
      end
      left_reg <= 3'h0;
      prompt_pend_reg <= 1'b0;
      read_pend_reg <= 1'b0;
    end else begin
      msg_reg <= msg_next;
      left_reg <= left_next;
      prompt_pend_reg <= prompt_pend_next;
      read_pend_reg <= read_pend_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign O_CMD_EN = tx_en;
  assign O_TX_EN = tx_en;
  assign O_SELECTED = selected_reg;
  assign O_READY = restored_reg;
  assign O_ID = id_reg;
  assign O_TX_VALID = busy;
  assign O_TX_DATA = msg_reg[0];
  assign O_NV_WR = nv_wr_reg;
  assign O_NV_DATA = nv_data_reg;

endmodule // dcas_top

// File: verification/dcas_asserts.sv
// Port-level assertions for the address selector
module dcas_asserts
  import dcas_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_ID_WR,
  input wire logic [7:0] I_ID_WR_DATA,
  input wire logic I_SAVE,
  input wire logic [7:0] I_NV_ID,
  input wire logic I_NV_VALID,
  input wire logic O_CMD_EN,
  input wire logic O_TX_EN,
  input wire logic O_SELECTED,
  input wire logic O_READY,
  input wire logic [7:0] O_ID,
  input wire logic O_TX_VALID,
  input wire logic O_NV_WR,
  input wire logic [7:0] O_NV_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_ok;
  function automatic logic [7:0] up(input logic [7:0] c);
    return (c >= CH_LOW_A && c <= CH_LOW_Z) ? c - CASE_BIT : c;
  endfunction
  function automatic logic id_ok(input logic [7:0] c);
    return (up(c) >= CH_0 && up(c) <= CH_9) || (up(c) >= CH_A && up(c) <= CH_Z);
  endfunction
  assign wr_ok = I_ID_WR && O_READY && (id_ok(I_ID_WR_DATA) || I_ID_WR_DATA == CH_WILD);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  // ****************************************
  // Sequences and checks
  // ****************************************
  sequence s_release;
    I_RST ##1 !I_RST;
  endsequence
  // Line start is known after reset or an end of line; the sequence needs an LF, so the bench always leads with one
  sequence s_at(logic mine);
    I_RX_VALID && I_RX_DATA == CH_LF ##1 I_RX_VALID && I_RX_DATA == CH_AT ##1 I_RX_VALID
      && id_ok(I_RX_DATA) && O_ID != CH_WILD && ((up(I_RX_DATA) == O_ID) == mine);
  endsequence
  // The release sequence starts inside reset, so the default disable must not apply
  property p_restore;
    disable iff (1'b0) s_release |=> O_READY && O_ID ==
      (($past(I_NV_VALID) && id_ok($past(I_NV_ID))) ? up($past(I_NV_ID)) : CH_WILD);
  endproperty
  AST_RESTORE: assert property (p_restore) else $error("restored id wrong");
  AST_EN_SAME: assert property (O_TX_EN == O_CMD_EN) else $error("enables differ");
  AST_WILD_OPEN: assert property (O_READY && O_ID == CH_WILD |-> O_CMD_EN)
    else $error("wildcard not answering");
  AST_TX_GATED: assert property ($rose(O_TX_VALID) |-> $past(O_TX_EN))
    else $error("message started while silent");
  AST_WR_TAKE: assert property (wr_ok |=> O_ID == up($past(I_ID_WR_DATA)))
    else $error("id write not applied");
  AST_ID_KEEP: assert property (O_READY && !wr_ok |=> $stable(O_ID))
    else $error("id changed without write");
  AST_SAVE: assert property (I_SAVE |=> O_NV_WR && O_NV_DATA == $past(O_ID))
    else $error("save not written");
  AST_NV_ONLY: assert property (O_NV_WR |-> $past(I_SAVE)) else $error("stray store write");
  AST_AT_SELECT: assert property (s_at(1'b1) |=> O_SELECTED && O_CMD_EN)
    else $error("prefix did not select");
  AST_AT_DROP: assert property (s_at(1'b0) |=> !O_SELECTED)
    else $error("prefix did not deselect");
endmodule // dcas_asserts

bind dcas_top dcas_asserts chk (.*);

// File: verification/dcas_host_model.sv
// Host side receiver with optional random stalls
module dcas_host_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed = 32'hf2a8;
  logic [7:0] got[$];
  initial o_tx_ready = 1'b1;
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
    o_tx_ready <= !i_slow || ($random(seed) % 3 == 0);
  end
endmodule // dcas_host_model

// File: verification/dcas_top_test.sv
// Self-checking bench for the address selector
module dcas_top_test
  import dcas_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, rxv = 0, idwr = 0, idrd = 0, preq = 0, save = 0, nvv = 0, slow = 0;
  logic [7:0] rxd = 0, wrd = 0, nvd = 0, b, cur;
  logic cmd_en, tx_en, sel, rdy, txv, tx_rdy, nvwr;
  logic [7:0] id, txd, nvdat;
  int err_total = 0, num_checks = 0, cycles = 0;
  integer seed = 32'hf2a8;
  string corner = "#z*7";
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
  dcas_top uut (.I_MCLK(clk), .I_RST(rst), .I_RX_VALID(rxv), .I_RX_DATA(rxd),
    .I_ID_WR(idwr), .I_ID_WR_DATA(wrd), .I_ID_RD(idrd), .I_PROMPT_REQ(preq),
    .I_SAVE(save), .I_NV_ID(nvd), .I_NV_VALID(nvv), .I_TX_READY(tx_rdy),
    .O_CMD_EN(cmd_en), .O_TX_EN(tx_en), .O_SELECTED(sel), .O_READY(rdy), .O_ID(id),
    .O_TX_VALID(txv), .O_TX_DATA(txd), .O_NV_WR(nvwr), .O_NV_DATA(nvdat));
  dcas_host_model host (.i_clk(clk), .i_slow(slow), .i_tx_valid(txv), .i_tx_data(txd),
    .o_tx_ready(tx_rdy));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // Nonvolatile store keeps only what was saved
  always @(negedge clk) if (nvwr) begin
    nvd = nvdat;
    nvv = 1;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] exp_id(logic [7:0] c, logic [7:0] old);
    logic [7:0] u;
    u = (c >= CH_LOW_A && c <= CH_LOW_Z) ? c - CASE_BIT : c;
    if (c == CH_WILD || (u >= CH_0 && u <= CH_9) || (u >= CH_A && u <= CH_Z)) return u;
    return old;
  endfunction
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task automatic send(string s);
    for (int k = 0; k < s.len(); k++) begin
      rxv = 1;
      rxd = s[k];
      @(negedge clk);
    end
    rxv = 0;
    tick(1);
  endtask
  task automatic wr_id(logic [7:0] c);
    wrd = c;
    pulse(idwr);
  endtask
  task automatic expect_msg(string s);
    int t;
    t = 0;
    while (host.got.size() < s.len() && t < 80) begin
      @(negedge clk);
      t++;
    end
    tick(8);
    `CHK(host.got.size(), s.len())
    for (int k = 0; k < s.len(); k++) `CHK(host.got[k], s[k])
    host.got.delete();
  endtask
  task automatic reset_dut;
    rst = 1;
    tick(6);
    rst = 0;
    tick(2);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_dut();
    `CHK(id, CH_WILD)
    `CHK(cmd_en, 1'b1)
    pulse(preq);
    expect_msg(">");
    pulse(idrd);
    expect_msg("ID=*");
    slow = 1;
    cur = CH_WILD;
    for (int i = 0; i < 24; i++) begin
      b = (i < 4) ? corner[i] : 8'($random(seed));
      cur = exp_id(b, cur);
      wr_id(b);
      `CHK(id, cur)
      // Random stalls can stretch a prompt; let it drain before clearing
      tick(3);
      while (txv) @(negedge clk);
      host.got.delete();
    end
    wr_id(8'h43);
    tick(3);
    while (txv) @(negedge clk);
    host.got.delete();
    pulse(save);
    tick(2);
    `CHK(nvd, 8'h43)
    send("\n@B");
    `CHK(sel, 1'b0)
    send("\ntalkc");
    `CHK(cmd_en, 1'b1)
    pulse(preq);
    expect_msg("C>");
    send("\n@5");
    `CHK(sel, 1'b0)
    pulse(preq);
    expect_msg("");
    send("\n@c");
    `CHK(sel, 1'b1)
    wr_id(8'h6b);
    `CHK(sel, 1'b1)
    expect_msg("K>");
    pulse(idrd);
    expect_msg("ID=K");
    reset_dut();
    `CHK(id, 8'h43)
    `CHK(tx_en, 1'b0)
    pulse(preq);
    expect_msg("");
    send("\n\\");
    `CHK(cmd_en, 1'b1)
    pulse(idrd);
    expect_msg("ID=C");
    send("\n@C");
    wr_id(CH_WILD);
    `CHK(id, CH_WILD)
    wrap_up();
  end
endmodule // dcas_top_test
